// file: rtl/scs_pkg.sv
// shared constants for the clock-stop serial port
package scs_pkg;
  localparam int          SCS_DATA_W      = 8;
  localparam int          SCS_FIFO_DEPTH  = 8;
  localparam int          SCS_DIV_W       = 8;
  localparam logic [1:0]  SCS_STOP_11     = 2'h3;
  localparam logic [1:0]  SCS_STOP_10     = 2'h2;
  localparam logic [7:0]  SCS_SLAVE_DIV   = 8'h01;
  localparam logic [7:0]  SCS_DIV_RESET   = 8'h01;
  localparam int          SCS_CLK_MHZ     = 40;
  localparam int          SCS_PERIOD_NS   = 25;

  typedef enum logic [5:0] {
    SCS_IDLE  = 6'h01,
    SCS_LEAD  = 6'h02,
    SCS_HIGH  = 6'h04,
    SCS_LOW   = 6'h08,
    SCS_TAIL  = 6'h10,
    SCS_SLAVE = 6'h20
  } scs_state_e;
endpackage

// file: rtl/scs_fifo_if.sv
// valid/ready carrier between the port and its fifo
`timescale 1ns/1ps
interface scs_fifo_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// file: rtl/scs_fifo.sv
// small synchronous fifo with registered read data
`timescale 1ns/1ps
module scs_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic clk_en,
  scs_fifo_if.snk   wr,
  scs_fifo_if.src   rd
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0]   cnt, next_cnt;
  logic [W-1:0]  dout, next_dout;
  logic          dval, next_dval;
  logic          push, pop, load;

  always_comb begin
    push      = wr.valid && wr.ready;
    load      = (cnt != '0) && (!dval || rd.ready);
    pop       = load;
    next_wp   = push ? AW'(wp + 1'b1) : wp;
    next_rp   = pop ? AW'(rp + 1'b1) : rp;
    next_cnt  = cnt + (AW+1)'(push) - (AW+1)'(pop);
    next_dout = load ? mem[rp] : dout;
    next_dval = load ? 1'b1 : (rd.ready ? 1'b0 : dval);
  end

  // the output register holds a word too, so it counts towards the depth
  assign wr.ready = ((cnt + (AW+1)'(dval)) < (AW+1)'(D));
  assign rd.data  = dout;
  assign rd.valid = dval;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      dout <= '0;
      dval <= 1'b0;
    end else if (clk_en) begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
      dout <= next_dout;
      dval <= next_dval;
      if (push && wr.ready) begin
        mem[wp] <= wr.data;
      end
    end
  end
endmodule

// file: rtl/scs_port.sv
// clock-stop serial port: generator, master/slave shifter, tx fifo
//
// Operation
// - shift period is input period times (1+divide)
// - high phase: div/2+1 even, (div+1)/2 odd
// - low phase: div/2 even, (div+1)/2 odd
// - source select 1 cpu clock, 0 pin
// - slave mode needs source 1, divide 1
// - master drives clock and frame, also receives data
// - select active low via polarity inversion
// - mode 11: select leads rise by period
// - mode 11: first bit high-phase after select
// - mode 11: select held low-phase after fall
// - mode 10: select leads fall by high-phase
// - mode 10: select held period after rise
// - sample input on rising clock edge; a slave with idle-high clock samples on the pin's falling edge
// - change output after falling clock edge; a slave with idle-high clock changes after the pin's rising edge
// - mode 10 master: tristate high-phase after rise
// - mode 10 slave: tristate after select rises
`timescale 1ns/1ps
module scs_port
  import scs_pkg::*;
#(
  parameter int DATA_W = SCS_DATA_W,
  parameter int DEPTH  = SCS_FIFO_DEPTH
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic [1:0]        clock_stop_mode,
  input  wire logic              shift_clock_polarity,
  input  wire logic              generator_source_select,
  input  wire logic [7:0]        clock_divide_value,
  input  wire logic              tx_clock_direction,
  input  wire logic              tx_frame_direction,
  input  wire logic              tx_frame_polarity,
  input  wire logic              rx_frame_polarity,
  input  wire logic              ext_gen_clock,
  input  wire logic [DATA_W-1:0] tx_data,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  output logic [DATA_W-1:0]      rx_data,
  output logic                   rx_valid,
  output logic                   shift_clock_o,
  output logic                   shift_clock_oe,
  input  wire logic              shift_clock_i,
  output logic                   tx_frame_select_o,
  output logic                   tx_frame_select_oe,
  input  wire logic              tx_frame_select_i,
  input  wire logic              rx_frame_sync,
  output logic                   serial_data_out,
  output logic                   serial_data_oe,
  input  wire logic              serial_data_in,
  output logic                   config_error
);
  localparam int CW = $clog2(DATA_W + 1);

  scs_fifo_if #(.W(DATA_W)) in_if ();
  scs_fifo_if #(.W(DATA_W)) out_if ();

  assign in_if.data  = tx_data;
  assign in_if.valid = tx_valid;

  scs_fifo #(.W(DATA_W), .D(DEPTH)) u_fifo (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .wr      (in_if.snk),
    .rd      (out_if.src)
  );

  // generator input tick; the external pin is edge-detected so S is one pin period
  logic ext_q, ext_rise, gen_tick;
  logic [7:0] h_len, l_len, hi_ph, lo_ph;
  always_comb begin
    ext_rise = ext_gen_clock && !ext_q;
    gen_tick = generator_source_select ? 1'b1 : ext_rise;
    if (clock_divide_value[0] == 1'b0 && clock_divide_value != 8'h00) begin
      h_len = (clock_divide_value >> 1) + 8'h01;
      l_len = clock_divide_value >> 1;
    end else begin
      h_len = 8'((9'(clock_divide_value) + 9'h001) >> 1);
      l_len = h_len;
    end
    // with an idle-high clock the pin low phase is the internal high one
    hi_ph = shift_clock_polarity ? l_len : h_len;
    lo_ph = shift_clock_polarity ? h_len : l_len;
  end

  wire master = tx_clock_direction && tx_frame_direction;
  // select as seen internally: active-high after polarity inversion
  wire sel_in = tx_frame_polarity ? !tx_frame_select_i : tx_frame_select_i;
  wire sel_rx = rx_frame_polarity ? !rx_frame_sync : rx_frame_sync;
  wire slave_sel = sel_in || sel_rx;
  wire mode11 = (clock_stop_mode == SCS_STOP_11);

  scs_state_e state, next_state;
  logic [7:0] ph_cnt, next_ph_cnt;
  logic [CW-1:0] bit_cnt, next_bit_cnt;
  logic [DATA_W-1:0] tsr, next_tsr, rsr, next_rsr;
  logic sclk, next_sclk, sel_act, next_sel_act, dout, next_dout, doe, next_doe;
  logic [DATA_W-1:0] rxd, next_rxd;
  logic rxv, next_rxv, pop;
  logic sclk_q, sel_q, next_sel_q, cfg_err, next_cfg_err;

  // a rising/falling edge of the logical shift clock (polarity removed)
  wire slv_clk  = shift_clock_i ^ shift_clock_polarity;
  wire slv_rise = slv_clk && !sclk_q;
  wire slv_fall = !slv_clk && sclk_q;
  // the registered clock pin rises at the next edge, whatever its idle level
  wire pin_rise = (sclk ^ shift_clock_polarity) && !shift_clock_o;

  assign out_if.ready = pop;

  always_comb begin
    next_state   = state;
    next_ph_cnt  = ph_cnt;
    next_bit_cnt = bit_cnt;
    next_tsr     = tsr;
    next_rsr     = rsr;
    next_sclk    = sclk;
    next_sel_act = sel_act;
    next_dout    = dout;
    next_doe     = doe;
    next_rxd     = rxd;
    next_rxv     = 1'b0;
    next_sel_q   = slave_sel;
    pop          = 1'b0;
    // slave clocking only works from a half-rate cpu-clocked generator
    next_cfg_err = !master && !(generator_source_select && clock_divide_value == SCS_SLAVE_DIV);
    case (state)
      SCS_IDLE: begin
        next_sclk = 1'b0;
        next_sel_act = 1'b0;
        if (master && out_if.valid && gen_tick) begin
          pop = 1'b1;
          next_tsr = out_if.data;
          next_sel_act = 1'b1;
          next_bit_cnt = CW'(DATA_W);
          // lead: mode 11 one period before rise, mode 10 one high phase
          next_ph_cnt = mode11 ? 8'(h_len + l_len) : h_len;
          next_doe = !mode11;
          next_dout = mode11 ? dout : out_if.data[DATA_W-1];
          next_state = SCS_LEAD;
        end else if (!master && slave_sel && !sel_q) begin
          next_state = SCS_SLAVE;
          next_bit_cnt = CW'(DATA_W);
          next_doe = 1'b1;
          if (out_if.valid) begin
            pop = 1'b1;
            next_tsr = out_if.data;
            next_dout = out_if.data[DATA_W-1];
          end else begin
            next_tsr = '0;
            next_dout = 1'b0;
          end
        end
      end
      SCS_LEAD: if (gen_tick) begin
        if (mode11 && ph_cnt == l_len + 8'h01) begin
          next_doe = 1'b1;
          next_dout = tsr[DATA_W-1];
        end
        if (ph_cnt <= 8'h01) begin
          next_ph_cnt = hi_ph;
          next_sclk = 1'b1;
          next_state = SCS_HIGH;
        end else begin
          next_ph_cnt = ph_cnt - 8'h01;
        end
      end
      SCS_HIGH: if (gen_tick) begin
        if (ph_cnt <= 8'h01) begin
          next_sclk = 1'b0;
          next_bit_cnt = bit_cnt - CW'(1);
          next_ph_cnt = (lo_ph == 8'h00) ? 8'h01 : lo_ph;
          if (bit_cnt != CW'(1)) begin
            if (!shift_clock_polarity) begin
              next_tsr = {tsr[DATA_W-2:0], 1'b0};
              next_dout = tsr[DATA_W-2];
            end
            next_state = SCS_LOW;
          end else begin
            next_ph_cnt = mode11 ? l_len : 8'(h_len + l_len);
            next_state = SCS_TAIL;
          end
        end else begin
          next_ph_cnt = ph_cnt - 8'h01;
        end
      end
      SCS_LOW: if (gen_tick) begin
        if (ph_cnt <= 8'h01) begin
          next_ph_cnt = hi_ph;
          next_sclk = 1'b1;
          if (shift_clock_polarity) begin
            // idle-high clock: the pin falls here, so the next bit goes out now
            next_tsr = {tsr[DATA_W-2:0], 1'b0};
            next_dout = tsr[DATA_W-2];
          end
          next_state = SCS_HIGH;
        end else begin
          next_ph_cnt = ph_cnt - 8'h01;
        end
      end
      SCS_TAIL: if (gen_tick) begin
        if (mode11 || ph_cnt == l_len + 8'h01) begin
          next_doe = mode11 ? 1'b0 : (ph_cnt > l_len + 8'h01 ? doe : 1'b0);
        end
        if (ph_cnt <= 8'h01) begin
          next_sel_act = 1'b0;
          next_doe = 1'b0;
          next_state = SCS_IDLE;
        end else begin
          next_ph_cnt = ph_cnt - 8'h01;
        end
      end
      SCS_SLAVE: begin
        if (slv_rise) begin
          next_rsr = {rsr[DATA_W-2:0], serial_data_in};
          next_bit_cnt = bit_cnt - CW'(1);
          if (bit_cnt == CW'(1)) begin
            next_rxd = {rsr[DATA_W-2:0], serial_data_in};
            next_rxv = 1'b1;
          end
        end
        if (slv_fall && bit_cnt != '0) begin
          next_tsr = {tsr[DATA_W-2:0], 1'b0};
          next_dout = tsr[DATA_W-2];
        end
        if (!slave_sel) begin
          next_doe = 1'b0;
          next_state = SCS_IDLE;
        end
      end
      default: next_state = SCS_IDLE;
    endcase
    // master samples where the clock pin rises; the last rise may fall in the tail
    if (master && state != SCS_IDLE && pin_rise) begin
      next_rsr = {rsr[DATA_W-2:0], serial_data_in};
      if (state == SCS_TAIL || (state == SCS_HIGH && bit_cnt == CW'(1))) begin
        next_rxd = {rsr[DATA_W-2:0], serial_data_in};
        next_rxv = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= SCS_IDLE;
      ph_cnt <= '0;
      bit_cnt <= '0;
      tsr <= '0;
      rsr <= '0;
      sclk <= 1'b0;
      sel_act <= 1'b0;
      dout <= 1'b0;
      doe <= 1'b0;
      rxd <= '0;
      rxv <= 1'b0;
      ext_q <= 1'b0;
      sclk_q <= 1'b0;
      sel_q <= 1'b0;
      cfg_err <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      ph_cnt <= next_ph_cnt;
      bit_cnt <= next_bit_cnt;
      tsr <= next_tsr;
      rsr <= next_rsr;
      sclk <= next_sclk;
      sel_act <= next_sel_act;
      dout <= next_dout;
      doe <= next_doe;
      rxd <= next_rxd;
      rxv <= next_rxv;
      ext_q <= ext_gen_clock;
      sclk_q <= slv_clk;
      sel_q <= next_sel_q;
      cfg_err <= next_cfg_err;
    end
  end

  // pin outputs registered once more so every output is a flip-flop
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      shift_clock_o <= 1'b0;
      shift_clock_oe <= 1'b0;
      tx_frame_select_o <= 1'b1;
      tx_frame_select_oe <= 1'b0;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
      rx_data <= '0;
      rx_valid <= 1'b0;
      tx_ready <= 1'b0;
      config_error <= 1'b0;
    end else if (clk_en) begin
      shift_clock_o <= sclk ^ shift_clock_polarity;
      shift_clock_oe <= master;
      tx_frame_select_o <= tx_frame_polarity ? !sel_act : sel_act;
      tx_frame_select_oe <= master;
      serial_data_out <= dout;
      serial_data_oe <= doe;
      rx_data <= rxd;
      rx_valid <= rxv;
      tx_ready <= in_if.ready;
      config_error <= cfg_err;
    end
  end

  chk_idle_clock_stopped: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == SCS_IDLE) |-> !sclk)
    else $error("shift clock not stopped in idle");
  chk_select_before_rise: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(sclk) |-> sel_act)
    else $error("clock rose without select");
  chk_tail_keeps_select: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == SCS_TAIL) |-> sel_act)
    else $error("select dropped during tail");
  chk_slave_tristate: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == SCS_SLAVE && !slave_sel && clk_en) |=> !doe)
    else $error("slave kept driving after deselect");
  chk_lead_select_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == SCS_LEAD) |-> (sel_act && !sclk))
    else $error("clock moved during select lead");
  chk_idle_select_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == SCS_IDLE) |-> !sel_act)
    else $error("select active while idle");
  chk_slave_config_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && !master && !(generator_source_select && clock_divide_value == SCS_SLAVE_DIV))
    |=> cfg_err)
    else $error("bad slave clocking not flagged");
endmodule

// file: test/scs_spi_peer.sv
// behavioural spi slave standing on the far side of the port
`timescale 1ns/1ps
module scs_spi_peer (
  input  wire logic       clk_sys,
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic [7:0] word,
  output logic            miso,
  output logic [7:0]      got
);
  logic [7:0] sh_out = 8'h00;
  logic       sclk_q = 1'b0;
  logic       pend   = 1'b0;
  logic       tog    = 1'b0;
  // deselected line floats, so show a pattern that changes every cycle
  assign miso = sel_n ? tog : sh_out[7];
  always @(posedge clk_sys) tog <= ~tog;
  // follows the pin edges directly, so the next bit is out long before the next rise
  always @(sclk or sel_n or word) begin
    if (sel_n) begin
      sh_out <= word;
      pend   <= 1'b0;
    end else if (sclk && !sclk_q) begin
      got  <= {got[6:0], mosi};
      pend <= 1'b1;
    end else if (!sclk && sclk_q && pend) begin
      // a leading fall before any sample must not shift
      sh_out <= {sh_out[6:0], 1'b0};
      pend   <= 1'b0;
    end
    sclk_q = sclk;
  end
endmodule

// file: test/scs_port_tb.sv
// self-checking bench for the clock-stop serial port
`timescale 1ns/1ps
module scs_port_tb;
  import scs_pkg::*;
  logic       clk_sys, reset_n, pol, src, tx_valid, tx_ready, rx_valid, mst, ssn;
  logic [1:0] mode, ec = 2'h0;
  logic [7:0] div, tx_data, rx_data, pw, got;
  logic       sck_o, sck_oe, sel_o, sel_oe, sdo, sdo_oe, sdi, cerr, sck, sel;
  logic       sck_q = 1'b0, sel_q = 1'b1, first = 1'b0, tck = 1'b0;
  int         num_errors, check_count, run, lead, hi, lo, tail, n, h, l, s, d;
  assign sck = sck_oe ? sck_o : tck;
  assign sel = sel_oe ? sel_o : ssn;
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // external generator clock: one rising edge every 4 cycles
  always @(posedge clk_sys) ec <= ec + 2'h1;
  scs_port #(.DATA_W(8), .DEPTH(8)) DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1), .clock_stop_mode(mode),
    .shift_clock_polarity(pol), .generator_source_select(src), .clock_divide_value(div),
    .tx_clock_direction(mst), .tx_frame_direction(mst), .tx_frame_polarity(1'b1),
    .rx_frame_polarity(1'b1), .ext_gen_clock(ec[1]), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .shift_clock_o(sck_o), .shift_clock_oe(sck_oe), .shift_clock_i(sck),
    .tx_frame_select_o(sel_o), .tx_frame_select_oe(sel_oe), .tx_frame_select_i(sel),
    .rx_frame_sync(ssn), .serial_data_out(sdo), .serial_data_oe(sdo_oe),
    .serial_data_in(sdi), .config_error(cerr));
  scs_spi_peer peer (.clk_sys(clk_sys), .sclk(sck), .sel_n(sel), .mosi(sdo),
    .word(pw), .miso(sdi), .got(got));
  // run lengths of clock phases, measured in cycles at the pins
  always @(posedge clk_sys) begin
    sck_q <= sck;
    sel_q <= sel;
    if (!sel && sel_q) begin
      run   <= 1;
      first <= 1'b1;
    end else if (!sel && sck != sck_q) begin
      if (first) lead <= run;
      else if (sck_q) hi <= run;
      else lo <= run;
      first <= 1'b0;
      run   <= 1;
    end else if (sel && !sel_q) tail <= run;
    else run <= run + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // leaves tx_valid high; the caller drops it
  task automatic wr(input logic [7:0] w);
    tx_data  <= w;
    tx_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (tx_ready !== 1'b1 && n < 40);
  endtask
  task automatic cfg(input logic [1:0] m, input logic p, input logic sr,
                     input logic [7:0] dv, input logic ms);
    mode <= m;
    pol  <= p;
    src  <= sr;
    div  <= dv;
    mst  <= ms;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic fin(input logic [7:0] w);
    n = 0;
    while (rx_valid !== 1'b1 && n < 900) begin
      @(posedge clk_sys);
      n++;
    end
    chk(rx_data, pw);
    while (sel !== 1'b1 && n < 900) begin
      @(posedge clk_sys);
      n++;
    end
    chk(got, w);
  endtask
  initial begin
    reset_n = 1'b0;
    {mode, pol, src, div, mst, ssn} = {SCS_STOP_11, 1'b0, 1'b1, 8'h03, 1'b1, 1'b1};
    {tx_valid, tx_data, pw, num_errors, check_count} = '0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      d = (i == 4) ? 1 : 3 + i % 2;
      s = (i == 4) ? 4 : 1;
      h = (d % 2 == 0) ? d / 2 + 1 : (d + 1) / 2;
      l = (d % 2 == 0) ? d / 2 : (d + 1) / 2;
      cfg((i == 2 || i == 3) ? SCS_STOP_10 : SCS_STOP_11, i == 2 || i == 3, i != 4,
          d[7:0], 1'b1);
      pw = ~(8'h96 ^ i[7:0]);
      wr(8'h96 ^ i[7:0]);
      tx_valid <= 1'b0;
      fin(8'h96 ^ i[7:0]);
      repeat (3) @(posedge clk_sys);
      chk(hi, h * s);
      chk(lo, l * s);
      chk(hi + lo, (d + 1) * s);
      if (pol) begin
        chk(lead, h * s);
        chk(tail, (d + 1) * s);
      end else begin
        chk(lead, (d + 1) * s);
        chk(tail, l * s);
      end
      chk({sck, sel_o, sdo_oe}, {pol, 2'h2});
      chk({sck_oe, sel_oe}, 2'h3);
    end
    cfg(SCS_STOP_11, 1'b0, 1'b1, 8'h02, 1'b0);
    chk(cerr, 1'b1);
    chk({sck_oe, sel_oe, sdo_oe}, 3'h0);
    cfg(SCS_STOP_11, 1'b0, 1'b1, SCS_SLAVE_DIV, 1'b0);
    chk(cerr, 1'b0);
    // the bench plays master: one word each way through the selected slave
    pw = 8'h5a;
    wr(8'ha5);
    tx_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    ssn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(sdo_oe, 1'b1);
    for (int i = 0; i < 8; i++) begin
      tck <= 1'b1;
      repeat (4) @(posedge clk_sys);
      tck <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    ssn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(rx_data, 8'h5a);
    chk(got, 8'ha5);
    chk(sdo_oe, 1'b0);
    // an unselected slave keeps every word, so the fifo must refuse
    d = 0;
    for (int i = 0; i < 12; i++) begin
      wr(8'h10 + i[7:0]);
      if (n >= 40) break;
      d++;
      tx_valid <= 1'b0;
      @(posedge clk_sys);
    end
    tx_valid <= 1'b0;
    chk(d, SCS_FIFO_DEPTH);
    pw = 8'h3c;
    cfg(SCS_STOP_11, 1'b0, 1'b1, 8'h03, 1'b1);
    for (int i = 0; i < SCS_FIFO_DEPTH; i++) fin(8'h10 + i[7:0]);
    conclude();
  end
  initial begin
    #500000;
    num_errors++;
    conclude();
  end
endmodule
